// ==== shared/ppd_pkg.sv ====
// Package for the pulse programming decoder: levels, states, widths and timing
package ppd_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  // Least pulse width in microseconds; low gaps have no minimum
  localparam int unsigned PULSE_MIN_US = 40;
  localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W = 16;
  // Chopper and sampling rates
  localparam int unsigned CHOP_HZ = 210000;
  localparam int unsigned SAMPLE_HZ = 2 * CHOP_HZ;
  localparam int unsigned SAMPLE_HALF_CYC = CLK_HZ / (2 * SAMPLE_HZ);
  localparam int unsigned DIV_W = 8;
  // Field widths
  localparam int unsigned CODE_W = 8;
  localparam int unsigned KEY_W = 3;
  localparam logic [KEY_W-1:0] KEY_ONE = 3'h1;
  localparam logic [KEY_W-1:0] KEY_TWO = 3'h2;
  localparam logic [CODE_W-1:0] CODE_MAX_SENS = 8'hff;
  localparam logic [CODE_W-1:0] CODE_MAX_QFINE = 8'hff;
  // Two coarse bits plus the lock bit above them, so the lock fuse can be addressed
  localparam logic [CODE_W-1:0] CODE_MAX_QCOARSE = 8'h07;
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] CODE_ONE = 8'h01;
  localparam logic [KEY_W-1:0] KEY_ZERO = 3'h0;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  // Coarse register lock bit position
  localparam int unsigned LOCK_BIT = 2;

  // Pin level classes from the comparators
  typedef enum logic [1:0] {
    PPD_LVL_LOW = 2'h0,
    PPD_LVL_MID = 2'h1,
    PPD_LVL_HIGH = 2'h3
  } ppd_lvl_t;

  // Sequence states, Gray coded along the path
  typedef enum logic [2:0] {
    PPD_ST_IDLE = 3'h0,
    PPD_ST_KEY1 = 3'h1,
    PPD_ST_CODE1 = 3'h3,
    PPD_ST_KEY2 = 3'h2,
    PPD_ST_CODE2 = 3'h6,
    PPD_ST_DEAD = 3'h7
  } ppd_state_t;

  // Programming modes
  typedef enum logic [1:0] {
    PPD_MODE_HOLD = 2'h0,
    PPD_MODE_TRY = 2'h1,
    PPD_MODE_BLOW = 2'h3,
    PPD_MODE_LOCK = 2'h2
  } ppd_mode_t;
endpackage

// ==== rtl/ppd_pulse_classifier.sv ====
// Pulse classifier: synchronises pin levels and emits validated pulse symbols
`timescale 1ns/100ps
`default_nettype none
module ppd_pulse_classifier (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Comparator levels from the output pin
  input wire logic mid_i,
  input wire logic high_i,
  // Symbols, one-cycle pulses at the falling edge
  output logic mid_pulse_o,
  output logic high_pulse_o
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [ppd_pkg::CNT_W-1:0] cnt;
    logic in_pulse;
    logic saw_high;
    logic mid_p;
    logic high_p;
  } ppd_cls_t;

  ppd_cls_t r;
  ppd_cls_t next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = {high_i, mid_i};
    next_r.s2 = r.s1;
    next_r.mid_p = 1'b0;
    next_r.high_p = 1'b0;
    if (r.s2 != 2'h0) begin
      next_r.in_pulse = 1'b1;
      if (r.s2[1]) begin
        next_r.saw_high = 1'b1;
      end
      // Saturate so a long hold never wraps back under the minimum
      if (r.cnt != {ppd_pkg::CNT_W{1'b1}}) begin
        next_r.cnt = r.cnt + 16'h0001;
      end
    end else begin
      // Short glitches are dropped as noise, not reported
      if (r.in_pulse && (r.cnt >= ppd_pkg::CNT_W'(ppd_pkg::PULSE_MIN_CYC))) begin
        next_r.high_p = r.saw_high;
        next_r.mid_p = !r.saw_high;
      end
      next_r.in_pulse = 1'b0;
      next_r.saw_high = 1'b0;
      next_r.cnt = ppd_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign mid_pulse_o = r.mid_p;
  assign high_pulse_o = r.high_p;
endmodule
`default_nettype wire

// ==== rtl/ppd_decoder.sv ====
// One-pin programming decoder: key/code addressing, trial settings, fuses, lock
`timescale 1ns/100ps
`default_nettype none
module ppd_decoder (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Pin level comparators on the analog output pin
  input wire logic analog_output_pin_mid_i,
  input wire logic analog_output_pin_high_i,
  // Mode controls
  input wire logic hold_mode_i,
  input wire logic blow_mode_i,
  // Fuse array state, read back
  input wire logic [ppd_pkg::CODE_W-1:0] fuse_sens_i,
  input wire logic [ppd_pkg::CODE_W-1:0] fuse_qfine_i,
  input wire logic [ppd_pkg::CODE_W-1:0] fuse_qcoarse_i,
  input wire logic fuse_lock_i,
  // Applied parameter codes
  output logic [ppd_pkg::CODE_W-1:0] sens_code_o,
  output logic [ppd_pkg::CODE_W-1:0] qfine_code_o,
  output logic [ppd_pkg::CODE_W-1:0] qcoarse_code_o,
  // Fuse blow request
  output logic blow_sens_o,
  output logic blow_qfine_o,
  output logic blow_qcoarse_o,
  output logic blow_lock_o,
  output logic [ppd_pkg::CODE_W-1:0] blow_bits_o,
  // Status
  output logic [1:0] mode_o,
  output logic locked_o,
  output logic disabled_o,
  // Chopper clocks
  output logic chop_clk_o,
  output logic sample_clk_o
);
  typedef struct packed {
    ppd_pkg::ppd_state_t st;
    logic [ppd_pkg::KEY_W-1:0] key;
    logic [1:0] zone;
    logic [ppd_pkg::CODE_W-1:0] code;
    logic [ppd_pkg::CODE_W-1:0] t_sens;
    logic [ppd_pkg::CODE_W-1:0] t_qfine;
    logic [ppd_pkg::CODE_W-1:0] t_qcoarse;
    logic [ppd_pkg::CODE_W-1:0] sens;
    logic [ppd_pkg::CODE_W-1:0] qfine;
    logic [ppd_pkg::CODE_W-1:0] qcoarse;
    logic b_sens;
    logic b_qfine;
    logic b_qcoarse;
    logic b_lock;
    logic [ppd_pkg::CODE_W-1:0] b_bits;
    logic [1:0] mode;
    logic locked;
    logic dead;
    logic [ppd_pkg::DIV_W-1:0] div;
    logic samp;
    logic chop;
  } ppd_dec_t;

  ppd_dec_t r;
  ppd_dec_t next_r;
  logic mid_p;
  logic high_p;
  logic [ppd_pkg::CODE_W-1:0] cmax;
  logic blk;

  ppd_pulse_classifier u_cls (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .mid_i(analog_output_pin_mid_i),
    .high_i(analog_output_pin_high_i),
    .mid_pulse_o(mid_p),
    .high_pulse_o(high_p)
  );

  // Maximum code of the selected register
  always_comb begin
    cmax = ppd_pkg::CODE_ZERO;
    if (r.zone == 2'h1 && r.key == ppd_pkg::KEY_ONE) begin
      cmax = ppd_pkg::CODE_MAX_SENS;
    end else if (r.zone == 2'h2 && r.key == ppd_pkg::KEY_ONE) begin
      cmax = ppd_pkg::CODE_MAX_QFINE;
    end else if (r.zone == 2'h2 && r.key == ppd_pkg::KEY_TWO) begin
      cmax = ppd_pkg::CODE_MAX_QCOARSE;
    end
  end

  always_comb begin
    next_r = r;
    blk = r.dead || fuse_lock_i;
    next_r.b_sens = 1'b0;
    next_r.b_qfine = 1'b0;
    next_r.b_qcoarse = 1'b0;
    next_r.b_lock = 1'b0;
    next_r.locked = fuse_lock_i;
    next_r.mode = blow_mode_i ? ppd_pkg::PPD_MODE_BLOW : (hold_mode_i ? ppd_pkg::PPD_MODE_HOLD : ppd_pkg::PPD_MODE_TRY);
    if (!blk && (mid_p || high_p)) begin
      unique case (r.st)
        ppd_pkg::PPD_ST_IDLE: begin
          if (high_p) begin
            next_r.st = ppd_pkg::PPD_ST_KEY1;
            next_r.zone = 2'h1;
            next_r.key = ppd_pkg::KEY_ZERO;
          end else begin
            next_r.dead = 1'b1;
          end
        end
        ppd_pkg::PPD_ST_KEY1, ppd_pkg::PPD_ST_KEY2: begin
          if (mid_p) begin
            next_r.key = r.key + ppd_pkg::KEY_ONE;
          end else if (r.key != ppd_pkg::KEY_ZERO) begin
            next_r.st = (r.st == ppd_pkg::PPD_ST_KEY1) ? ppd_pkg::PPD_ST_CODE1 : ppd_pkg::PPD_ST_CODE2;
            next_r.code = ppd_pkg::CODE_ZERO;
          end else begin
            next_r.dead = 1'b1;
          end
        end
        ppd_pkg::PPD_ST_CODE1, ppd_pkg::PPD_ST_CODE2: begin
          if (mid_p) begin
            if (cmax == ppd_pkg::CODE_ZERO) begin
              next_r.dead = 1'b1;
            end else if (r.code != cmax) begin
              next_r.code = r.code + ppd_pkg::CODE_ONE;
            end
          end else if (r.st == ppd_pkg::PPD_ST_CODE1) begin
            next_r.st = ppd_pkg::PPD_ST_KEY2;
            next_r.zone = 2'h2;
            next_r.key = ppd_pkg::KEY_ZERO;
          end else if (r.mode == ppd_pkg::PPD_MODE_BLOW && r.code != ppd_pkg::CODE_ZERO) begin
            // A high pulse after the code is the blow pulse
            next_r.b_bits = r.code;
            next_r.b_sens = (r.zone == 2'h1);
            next_r.b_qfine = (r.key == ppd_pkg::KEY_ONE);
            next_r.b_qcoarse = (r.key == ppd_pkg::KEY_TWO);
            next_r.b_lock = (r.key == ppd_pkg::KEY_TWO) && r.code[ppd_pkg::LOCK_BIT];
          end else begin
            next_r.dead = 1'b1;
          end
        end
        default: begin
          next_r.dead = 1'b1;
        end
      endcase
    end
    if (next_r.dead) begin
      next_r.st = ppd_pkg::PPD_ST_DEAD;
    end
    // Zone-1 blow pulses are also accepted before leaving zone 1
    if (!blk && high_p && r.st == ppd_pkg::PPD_ST_CODE1 && r.mode == ppd_pkg::PPD_MODE_BLOW
        && r.code != ppd_pkg::CODE_ZERO) begin
      next_r.b_bits = r.code;
      next_r.b_sens = 1'b1;
    end
    // Trial values live only here, so power-up reset clears them; blown bits persist in fuses
    if (r.st == ppd_pkg::PPD_ST_CODE1) begin
      next_r.t_sens = r.code;
    end
    if (r.st == ppd_pkg::PPD_ST_CODE2) begin
      // Try mode also clears the zone-1 trial value (t_sens) while a zone-2 register is addressed
      if (r.mode == ppd_pkg::PPD_MODE_TRY) begin
        next_r.t_sens = ppd_pkg::CODE_ZERO;
      end
      if (r.key == ppd_pkg::KEY_ONE) begin
        next_r.t_qfine = r.code;
      end else if (r.key == ppd_pkg::KEY_TWO) begin
        next_r.t_qcoarse = r.code;
      end
    end
    // Hold mode keeps both zones' trial values together
    if (r.mode == ppd_pkg::PPD_MODE_HOLD) begin
      next_r.t_sens = (r.st == ppd_pkg::PPD_ST_CODE1) ? r.code : r.t_sens;
    end
    next_r.sens = fuse_sens_i | r.t_sens;
    next_r.qfine = fuse_qfine_i | r.t_qfine;
    next_r.qcoarse = fuse_qcoarse_i | r.t_qcoarse;
    // Sampling at twice the chopper rate; chopper divides it by two
    if (r.div == ppd_pkg::DIV_W'(ppd_pkg::SAMPLE_HALF_CYC - 1)) begin
      next_r.div = ppd_pkg::DIV_ZERO;
      next_r.samp = !r.samp;
      if (r.samp) begin
        next_r.chop = !r.chop;
      end
    end else begin
      next_r.div = r.div + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sens_code_o = r.sens;
  assign qfine_code_o = r.qfine;
  assign qcoarse_code_o = r.qcoarse;
  assign blow_sens_o = r.b_sens;
  assign blow_qfine_o = r.b_qfine;
  assign blow_qcoarse_o = r.b_qcoarse;
  assign blow_lock_o = r.b_lock;
  assign blow_bits_o = r.b_bits;
  assign mode_o = r.mode;
  assign locked_o = r.locked;
  assign disabled_o = r.dead;
  assign chop_clk_o = r.chop;
  assign sample_clk_o = r.samp;
endmodule
`default_nettype wire

// ==== test/ppd_decoder_checker.sv ====
// Checker for the pulse programming decoder ports
`timescale 1ns/100ps
`default_nettype none
module ppd_decoder_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Inputs
  input wire logic hold_mode_i,
  input wire logic blow_mode_i,
  input wire logic [7:0] fuse_sens_i,
  input wire logic fuse_lock_i,
  // Outputs
  input wire logic [7:0] sens_code_o,
  input wire logic blow_sens_o,
  input wire logic blow_qfine_o,
  input wire logic blow_qcoarse_o,
  input wire logic blow_lock_o,
  input wire logic [1:0] mode_o,
  input wire logic locked_o,
  input wire logic disabled_o,
  input wire logic sample_clk_o,
  input wire logic chop_clk_o
);
  // Half period of the sample clock in clock cycles, as the divider counts it
  localparam logic [7:0] HALF_CYC = ppd_pkg::DIV_W'(ppd_pkg::SAMPLE_HALF_CYC);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire blow_any = blow_sens_o | blow_qfine_o | blow_qcoarse_o | blow_lock_o;
  logic prev;
  logic seen;
  logic [7:0] cnt;
  // First toggle after reset has no reference, so it is only recorded
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev <= 1'b0;
      seen <= 1'b0;
      cnt <= 8'h00;
    end else begin
      prev <= sample_clk_o;
      cnt <= (prev != sample_clk_o) ? 8'h01 : cnt + 8'h01;
      seen <= seen | (prev != sample_clk_o);
    end
  end
  chk_sample_half: assert property (seen && (prev != sample_clk_o) |-> cnt == HALF_CYC)
    else $error("sample clock half period wrong");
  chk_chop_step: assert property ($fell(sample_clk_o) == $changed(chop_clk_o))
    else $error("chopper clock not half the sample rate");
  chk_blow_pulse: assert property (blow_any |=> !blow_any)
    else $error("blow request longer than one cycle");
  chk_blow_mode: assert property (blow_any |-> mode_o == 2'h3)
    else $error("blow outside blow mode");
  chk_mode_follow: assert property ($past(nrst_i) |-> mode_o == ($past(blow_mode_i) ? 2'h3 :
    ($past(hold_mode_i) ? 2'h0 : 2'h1)))
    else $error("mode does not follow controls");
  chk_lock_copy: assert property ($past(nrst_i) |-> locked_o == $past(fuse_lock_i))
    else $error("lock status wrong");
  chk_lock_quiet: assert property (locked_o |-> !blow_any)
    else $error("blow while locked");
  chk_dis_sticky: assert property (disabled_o |=> disabled_o)
    else $error("disable dropped");
  chk_dis_frozen: assert property (disabled_o && $stable(fuse_sens_i) |=> $stable(sens_code_o))
    else $error("code moved while disabled");
  chk_fuse_kept: assert property ($past(nrst_i, 3) && $stable(fuse_sens_i) |->
    (sens_code_o & fuse_sens_i) == fuse_sens_i)
    else $error("blown bit lost from code");
  cov_blow: cover property (blow_sens_o);
  cov_dis: cover property ($rose(disabled_o));
  cov_code: cover property ($changed(sens_code_o));
endmodule
bind ppd_decoder ppd_decoder_checker chk (.clk_i(clk_i), .nrst_i(nrst_i), .hold_mode_i(hold_mode_i),
  .blow_mode_i(blow_mode_i), .fuse_sens_i(fuse_sens_i), .fuse_lock_i(fuse_lock_i), .sens_code_o(sens_code_o),
  .blow_sens_o(blow_sens_o), .blow_qfine_o(blow_qfine_o), .blow_qcoarse_o(blow_qcoarse_o),
  .blow_lock_o(blow_lock_o), .mode_o(mode_o), .locked_o(locked_o), .disabled_o(disabled_o),
  .sample_clk_o(sample_clk_o), .chop_clk_o(chop_clk_o));
`default_nettype wire

// ==== test/ppd_programmer.sv ====
// Programmer model that drives pulse levels onto the output pin
`timescale 1ns/100ps
`default_nettype none
module ppd_programmer (
  // Clock
  input wire logic clk_i,
  // Pulse command
  input wire logic go_i,
  input wire logic high_i,
  input wire logic [15:0] width_i,
  // Pin comparator levels and status
  output logic pin_mid_o,
  output logic pin_high_o,
  output logic busy_o
);
  int cnt = 0;
  int wid = 0;
  logic hi = 1'b0;
  // Pulse of width_i cycles, then an equal low gap
  always @(posedge clk_i) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (go_i) begin
      cnt <= 2 * width_i;
      wid <= width_i;
      hi <= high_i;
    end
  end
  // A high level also passes the mid threshold
  assign pin_mid_o = cnt > wid;
  assign pin_high_o = (cnt > wid) & hi;
  assign busy_o = cnt != 0;
endmodule
`default_nettype wire

// ==== test/pulse_programming_decoder_bench.sv ====
// Self-checking bench for the pulse programming decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module pulse_programming_decoder_bench;
  typedef struct {int sel; logic [7:0] v;} ppd_note_t;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hold = 1'b0, blow = 1'b0, lock = 1'b0, go = 1'b0, hi = 1'b0;
  logic [7:0] fs = 8'h00, fq = 8'h00, fc = 8'h00;
  logic [15:0] wid = 16'h064a;
  logic pm, ph, busy, bs, locked, dis;
  logic [7:0] sens, qfine, qcoarse, bits;
  logic [7:0] nblow = 8'h00;
  logic [31:0] rnd = 32'hfa5884da;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  ppd_note_t q[$];
  ppd_note_t n;
  event res_ev;
  always #12.5 clk_i = ~clk_i;
  ppd_programmer prog (.clk_i(clk_i), .go_i(go), .high_i(hi), .width_i(wid), .pin_mid_o(pm),
    .pin_high_o(ph), .busy_o(busy));
  ppd_decoder dut (.clk_i(clk_i), .nrst_i(nrst_i), .analog_output_pin_mid_i(pm),
    .analog_output_pin_high_i(ph), .hold_mode_i(hold), .blow_mode_i(blow), .fuse_sens_i(fs),
    .fuse_qfine_i(fq), .fuse_qcoarse_i(fc), .fuse_lock_i(lock), .sens_code_o(sens), .qfine_code_o(qfine),
    .qcoarse_code_o(qcoarse), .blow_sens_o(bs), .blow_qfine_o(), .blow_qcoarse_o(), .blow_lock_o(),
    .blow_bits_o(bits), .mode_o(), .locked_o(locked), .disabled_o(dis), .chop_clk_o(), .sample_clk_o());
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic note(input int s, input logic [7:0] v);
    q.push_back('{s, v});
    -> res_ev;
  endtask
  task automatic restart(input logic h, input logic b, input logic l);
    @(posedge clk_i);
    rnd = lfsr(rnd);
    nrst_i <= 1'b0;
    hold <= h;
    blow <= b;
    lock <= l;
    fs <= rnd[7:0];
    fq <= rnd[15:8];
    fc <= {6'h00, rnd[17:16]};
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    note(0, fs);
    note(1, fq);
    note(5, fc);
    note(6, {7'h00, l});
  endtask
  task automatic pulse(input logic h, input int k);
    repeat (k) begin
      @(posedge clk_i);
      go <= 1'b1;
      hi <= h;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      while (busy) @(posedge clk_i);
    end
    @(negedge clk_i);
  endtask
  // High, key mids, high, code mids
  task automatic sel(input int k, input int c);
    pulse(1'b1, 1);
    pulse(1'b0, k);
    pulse(1'b1, 1);
    pulse(1'b0, c);
  endtask
  always @(posedge clk_i) begin
    nblow <= nblow + {7'h00, bs};
    cyc++;
    if (cyc == 98000) begin
      err_count++;
      stop_test();
    end
  end
  always @(res_ev) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.sel)
        0: `CHK(sens, n.v)
        1: `CHK(qfine, n.v)
        2: `CHK(bits, n.v)
        3: `CHK({7'h00, dis}, n.v)
        5: `CHK(qcoarse, n.v)
        6: `CHK({7'h00, locked}, n.v)
        default: `CHK(nblow, n.v)
      endcase
    end
  end
  initial begin
    restart(1'b1, 1'b0, 1'b0);
    wid <= 16'h00c8;
    pulse(1'b0, 1);
    note(3, 8'h00);
    wid <= 16'h064a;
    sel(1, 3);
    note(0, fs | 8'h03);
    sel(1, 2);
    note(1, fq | 8'h02);
    note(0, fs | 8'h03);
    $display("hold test done");
    restart(1'b0, 1'b0, 1'b0);
    sel(1, 1);
    note(0, fs | 8'h01);
    sel(1, 1);
    note(1, fq | 8'h01);
    note(0, fs);
    $display("try test done");
    restart(1'b0, 1'b1, 1'b0);
    sel(1, 1);
    pulse(1'b1, 1);
    note(2, 8'h01);
    note(4, 8'h01);
    $display("blow test done");
    restart(1'b1, 1'b0, 1'b1);
    pulse(1'b0, 1);
    note(3, 8'h00);
    $display("lock test done");
    restart(1'b1, 1'b0, 1'b0);
    pulse(1'b0, 1);
    note(3, 8'h01);
    $display("illegal test done");
    @(posedge clk_i);
    stop_test();
  end
endmodule
`default_nettype wire
